// *** rtl/cpmbt_top.sv ***
// Power-mode sequencing, timer link and bit timing of the CAN controller
`timescale 1ns/1ps

// Notes on behaviour
// RQ1: Sleep request during transmit waits until nothing is scheduled.
// RQ2: Sleep request during receive waits for the message end.
// RQ3: Sleep request while idle enters sleep at once.
// RQ4: Sleep acknowledge stands for as long as the block sleeps.
// RQ5: Bus-off recovery count pauses in sleep and resumes after.
// RQ6: Sleep stops protocol timing, keeps register access, holds transmit recessive.
// RQ7: Sleep allows flag and buffer access but no copy or abort.
// RQ8: Sleep ends on bus activity, request withdrawn, or soft reset.
// RQ9: Sleep request cannot drop before sleep acknowledge is set.
// RQ10: After wakeup, eleven recessive bits are needed before joining.
// RQ11: Deferred copy, abort and transmit actions run upon wakeup.
// RQ12: Soft reset halts and aborts at once; registers stay reachable.
// RQ13: Software should sleep the block before soft reset or stop.
// RQ14: CPU stop means power-down: abort, transmit recessive, no access.
// RQ15: Bus activity in power-down wakes system; data ignored until resync.
// RQ16: During CPU wait the block runs and its interrupts end wait.
// RQ17: Wakeup filter select low-pass filters receive input while asleep.
// RQ18: A one-bit-time pulse follows every valid frame end.
// RQ19: Timer link enable routes that pulse to timer capture channel zero.
// RQ20: Clock source select picks PLL when one, oscillator when zero.
// RQ21: Prescaler divides module clock into the quantum clock.
// RQ22: Sync segment is one quantum; first segment 4 to 16.
// RQ23: Second segment 2 to 8 quanta; jump width 1 to 4.
// RQ24: Sampling at first segment end; third sample when triple sampling.
// RQ25: Timing fields hold length minus one, within their legal codes.
// RQ26: Quanta per bit is one plus both segment lengths.
module cpmbt_top import cpmbt_pkg::*; #(
  parameter int unsigned FILT_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic pll_tick,
  input wire logic clock_source_select,
  input wire cpmbt_timing_t timing,
  input wire logic can_rx_pin,
  input wire logic engine_tx_bit,
  input wire cpmbt_proto_t proto,
  input wire logic sleep_request,
  input wire logic soft_reset_request,
  input wire logic wakeup_filter_select,
  input wire logic timer_link_enable,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  input wire logic [2:0] irq_pending,
  output logic can_tx_pin,
  output logic sleep_acknowledge,
  output logic sleep_request_held,
  output logic bus_joined,
  output logic engine_rx_bit,
  output logic engine_sample,
  output logic deferred_action_enable,
  output logic register_access_enable,
  output logic abort_all,
  output logic wakeup_event,
  output logic busoff_recovered,
  output logic frame_valid_pulse,
  output logic first_timer_module_ch0,
  output logic wait_wakeup
);

  // Filter counter must reach the full filter length
  if (WUP_FILT_CYC >= (64'h1 << FILT_W)) begin : g_filt_w_bad
    $error("FILT_W too small for wakeup filter");
  end

  cpmbt_mode_t mode_ff;
  cpmbt_mode_t nxt_mode;
  logic req_ff;
  logic nxt_req;
  logic hold_ff;
  logic ack_ff;
  logic joined_ff;
  logic [3:0] rec_run_ff;
  logic [3:0] bo_run_ff;
  logic [7:0] bo_grp_ff;
  logic bo_done_ff;
  logic [FILT_W-1:0] filt_ff;
  logic tx_pin_ff;
  logic rx_out_ff;
  logic samp_out_ff;
  logic act_ff;
  logic acc_ff;
  logic abort_ff;
  logic wake_ev_ff;
  logic arm_ff;
  logic pulse_ff;
  logic ch0_ff;
  logic wait_ff;

  logic rx_sync;
  logic sample_pt;
  logic bit_start;
  logic rx_bit;

  // Pin input crosses into clk here
  cpmbt_sync #(
    .RST_VAL(RECESSIVE)
  ) i_cpmbt_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .din(can_rx_pin),
    .dout(rx_sync)
  );

  // RQ20 module clock source
  wire logic mod_tick = clock_source_select ? pll_tick : osc_tick;

  // Sleep-pending keeps timing so a frame in flight completes
  // RQ6 protocol timing only while running
  wire logic proto_run = (mode_ff == M_NORMAL) || (mode_ff == M_SLEEP_PEND);

  cpmbt_tq i_cpmbt_tq (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(proto_run),
    .mod_tick(mod_tick),
    .cfg(timing),
    .rx(rx_sync),
    .sample_pt(sample_pt),
    .bit_start(bit_start),
    .rx_bit(rx_bit)
  );

  // RQ1 nothing scheduled or sending
  // RQ2 no reception under way
  wire logic idle = !proto.tx_active && !proto.rx_active && !proto.tx_pending;

  // A bus wake blocks re-arming until software drops its request
  wire logic req_eff = req_ff && !hold_ff;

  wire logic asleep = (mode_ff == M_SLEEP);
  wire logic dominant = (rx_sync != RECESSIVE);

  // RQ17 glitch filter on receive while asleep
  wire logic filt_full = (filt_ff == FILT_W'(WUP_FILT_CYC - 1));
  wire logic bus_wake = asleep && dominant && (!wakeup_filter_select || filt_full);

  wire logic recessive_smp = sample_pt && (rx_bit == RECESSIVE);
  wire logic join_now = recessive_smp && (rec_run_ff == JOIN_BITS - 4'h1);
  wire logic bo_group = recessive_smp && (bo_run_ff == JOIN_BITS - 4'h1);

  // Mode sequencing; stop and soft reset override everything
  // Halted modes leave through normal, never straight to sleep
  always_comb begin
    nxt_mode = mode_ff;
    // RQ14 stop forces power-down
    if (cpu_stop) begin
      nxt_mode = M_PDOWN;
    // RQ12 soft reset halts at once
    end else if (soft_reset_request) begin
      nxt_mode = M_SOFT_RST;
    end else begin
      unique case (mode_ff)
        M_NORMAL: begin
          // RQ3 idle enters sleep directly
          if (req_eff && idle) nxt_mode = M_SLEEP;
          else if (req_eff) nxt_mode = M_SLEEP_PEND;
        end
        M_SLEEP_PEND: begin
          // RQ1 finish scheduled traffic first
          if (idle) nxt_mode = M_SLEEP;
        end
        M_SLEEP: begin
          // RQ8 wake conditions
          if (bus_wake || !req_eff) nxt_mode = M_NORMAL;
        end
        M_SOFT_RST: nxt_mode = M_NORMAL;
        M_PDOWN: nxt_mode = M_NORMAL;
        default: nxt_mode = M_NORMAL;
      endcase
    end
  end

  // Held request; a bus wake wins over a standing request
  always_comb begin
    nxt_req = req_ff;
    if (bus_wake) nxt_req = 1'b0;
    else if (sleep_request && !hold_ff) nxt_req = 1'b1;
    // RQ9 drop only after acknowledge
    else if (!sleep_request && ack_ff) nxt_req = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_ff <= M_NORMAL;
      req_ff <= 1'b0;
      hold_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else if (ce) begin
      mode_ff <= nxt_mode;
      req_ff <= nxt_req;
      // Set wins over clear
      hold_ff <= bus_wake || (hold_ff && sleep_request);
      // RQ4 acknowledge follows sleep state
      ack_ff <= (nxt_mode == M_SLEEP);
    end
  end

  // Wakeup filter: dominant must persist to count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      filt_ff <= '0;
    end else if (ce) begin
      if (!asleep || !dominant) filt_ff <= '0;
      else if (!filt_full) filt_ff <= filt_ff + FILT_W'(1);
    end
  end

  // RQ10 resync on recessive run
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rec_run_ff <= 4'h0;
      joined_ff <= 1'b0;
    end else if (ce) begin
      if (!proto_run) begin
        rec_run_ff <= 4'h0;
        joined_ff <= 1'b0;
      end else if (sample_pt) begin
        if (rx_bit != RECESSIVE) rec_run_ff <= 4'h0;
        else if (!join_now) rec_run_ff <= rec_run_ff + 4'h1;
        if (join_now) joined_ff <= 1'b1;
      end
    end
  end

  // RQ5 bus-off recovery count
  // Counters advance only on sample points, which stop in sleep
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bo_run_ff <= 4'h0;
      bo_grp_ff <= 8'h00;
      bo_done_ff <= 1'b0;
    end else if (ce) begin
      bo_done_ff <= 1'b0;
      if (!proto.bus_off) begin
        bo_run_ff <= 4'h0;
        bo_grp_ff <= 8'h00;
      end else if (sample_pt) begin
        if (rx_bit != RECESSIVE) bo_run_ff <= 4'h0;
        else if (bo_group) bo_run_ff <= 4'h0;
        else bo_run_ff <= bo_run_ff + 4'h1;
        if (bo_group && bo_grp_ff == BO_GROUPS - 8'h01) begin
          bo_grp_ff <= 8'h00;
          bo_done_ff <= 1'b1;
        end else if (bo_group) begin
          bo_grp_ff <= bo_grp_ff + 8'h01;
        end
      end
    end
  end

  // RQ6 transmit recessive when not running
  // RQ14 also in power-down
  wire logic nxt_tx_pin = (proto_run && joined_ff) ? engine_tx_bit : RECESSIVE;
  // RQ15 data ignored until rejoined
  wire logic nxt_rx_out = joined_ff ? rx_bit : RECESSIVE;
  // A sample launched just before sleep must not leak out
  wire logic nxt_samp_out = proto_run && joined_ff && sample_pt;

  // Pin and engine-facing data
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_pin_ff <= RECESSIVE;
      rx_out_ff <= RECESSIVE;
      samp_out_ff <= 1'b0;
    end else if (ce) begin
      tx_pin_ff <= nxt_tx_pin;
      rx_out_ff <= nxt_rx_out;
      samp_out_ff <= nxt_samp_out;
    end
  end

  // RQ7 no copy or abort while asleep
  // RQ11 deferred actions resume on wake
  wire logic nxt_act = (nxt_mode == M_NORMAL) || (nxt_mode == M_SLEEP_PEND);
  // RQ14 no register access in power-down
  wire logic nxt_acc = (nxt_mode != M_PDOWN);
  // RQ12 abort on entry to a halted mode from normal or sleep-pending
  wire logic nxt_abort = proto_run && ((nxt_mode == M_SOFT_RST) || (nxt_mode == M_PDOWN));
  // RQ15 bus activity wakes the system
  wire logic nxt_wake_ev = bus_wake || ((mode_ff == M_PDOWN) && dominant);
  // RQ16 enabled interrupts end CPU wait
  wire logic nxt_wait = cpu_wait && proto_run && (|irq_pending);

  // Access and action enables
  always_ff @(posedge clk) begin
    if (!nrst) begin
      act_ff <= 1'b0;
      acc_ff <= 1'b0;
      abort_ff <= 1'b0;
      wake_ev_ff <= 1'b0;
      wait_ff <= 1'b0;
    end else if (ce) begin
      act_ff <= nxt_act;
      acc_ff <= nxt_acc;
      abort_ff <= nxt_abort;
      wake_ev_ff <= nxt_wake_ev;
      wait_ff <= nxt_wait;
    end
  end

  // Frame-valid pulse spans one whole bit from the next bit start
  wire logic nxt_pulse = proto_run && (bit_start ? arm_ff : pulse_ff);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      arm_ff <= 1'b0;
      pulse_ff <= 1'b0;
      ch0_ff <= 1'b0;
    end else if (ce) begin
      // RQ18 pulse after valid frame
      arm_ff <= proto_run && ((proto.frame_ok && proto_run) || (arm_ff && !bit_start));
      pulse_ff <= nxt_pulse;
      // RQ19 routed to capture channel
      ch0_ff <= nxt_pulse && timer_link_enable;
    end
  end

  assign can_tx_pin = tx_pin_ff;
  assign sleep_acknowledge = ack_ff;
  assign sleep_request_held = req_ff;
  assign bus_joined = joined_ff;
  assign engine_rx_bit = rx_out_ff;
  assign engine_sample = samp_out_ff;
  assign deferred_action_enable = act_ff;
  assign register_access_enable = acc_ff;
  assign abort_all = abort_ff;
  assign wakeup_event = wake_ev_ff;
  assign busoff_recovered = bo_done_ff;
  assign frame_valid_pulse = pulse_ff;
  assign first_timer_module_ch0 = ch0_ff;
  assign wait_wakeup = wait_ff;

endmodule // cpmbt_top

// *** rtl/cpmbt_pkg.sv ***
// Shared constants and types for the CAN power-mode and bit-timing block
package cpmbt_pkg;

  // Module clock period and wakeup glitch filter time
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned WUP_FILT_NS = 2000;
  // Least time: rounded up to whole cycles
  localparam int unsigned WUP_FILT_CYC = (WUP_FILT_NS + CLK_NS - 1) / CLK_NS;

  // Recessive bits needed to join the bus
  localparam logic [3:0] JOIN_BITS = 4'hB;
  // Groups of recessive bits for bus-off recovery
  localparam logic [7:0] BO_GROUPS = 8'h80;

  // Smallest legal timing field codes
  localparam logic [3:0] FIRST_TIME_SEGMENT_LENGTH_MIN_F = 4'h3;
  localparam logic [2:0] SECOND_TIME_SEGMENT_LENGTH_MIN_F = 3'h1;

  // Bus levels and reset values
  localparam logic RECESSIVE = 1'b1;
  localparam logic [5:0] PRESC_RST = 6'h00;
  localparam logic [5:0] QPOS_RST = 6'h00;

  // Bit timing configuration; each field but three_samp holds length minus one
  typedef struct packed {
    logic [5:0] presc;
    logic [1:0] sjw;
    logic [3:0] first_time_segment_length;
    logic [2:0] second_time_segment_length;
    logic three_samp;
  } cpmbt_timing_t;

  // Status from the protocol engine, all on clk
  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic tx_pending;
    logic bus_off;
    logic frame_ok;
  } cpmbt_proto_t;

  typedef enum logic [2:0] {
    M_NORMAL,
    M_SLEEP_PEND,
    M_SLEEP,
    M_SOFT_RST,
    M_PDOWN
  } cpmbt_mode_t;

endpackage

// *** rtl/cpmbt_sync.sv ***
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module cpmbt_sync import cpmbt_pkg::*; #(
  parameter logic RST_VAL = RECESSIVE
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  wire logic agree = (s2_ff == s3_ff);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      out_ff <= RST_VAL;
    end else if (ce) begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) out_ff <= s3_ff;
    end
  end

  assign dout = out_ff;

endmodule // cpmbt_sync

// *** rtl/cpmbt_tq.sv ***
// Time-quantum prescaler and bit segment timer
`timescale 1ns/1ps
module cpmbt_tq import cpmbt_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic mod_tick,
  input wire cpmbt_timing_t cfg,
  input wire logic rx,
  output logic sample_pt,
  output logic bit_start,
  output logic rx_bit
);

  logic [5:0] presc_ff;
  logic [5:0] q_ff;
  logic [5:0] ext_ff;
  logic [2:0] hist_ff;
  logic samp_ff;
  logic start_ff;
  logic bit_ff;

  // RQ25 codes below minimum clamp up
  wire logic [3:0] t1_f = (cfg.first_time_segment_length < FIRST_TIME_SEGMENT_LENGTH_MIN_F) ? FIRST_TIME_SEGMENT_LENGTH_MIN_F : cfg.first_time_segment_length;
  wire logic [2:0] t2_f = (cfg.second_time_segment_length < SECOND_TIME_SEGMENT_LENGTH_MIN_F) ? SECOND_TIME_SEGMENT_LENGTH_MIN_F : cfg.second_time_segment_length;
  wire logic [5:0] sjw_q = {4'h0, cfg.sjw} + 6'h01;
  // RQ22 one sync quantum
  wire logic [5:0] samp_q = {2'h0, t1_f} + 6'h01 + ext_ff;
  wire logic [5:0] end_q = samp_q + {3'h0, t2_f} + 6'h01;
  wire logic tq = run && mod_tick && (presc_ff == cfg.presc);
  wire logic fall = hist_ff[0] && !rx && (q_ff != 6'h00);
  wire logic in_t1 = (q_ff <= samp_q);
  wire logic [5:0] jump_q = q_ff + sjw_q;
  wire logic at_end = (q_ff == end_q) || (fall && !in_t1 && jump_q >= end_q);
  wire logic maj = (hist_ff[1] & hist_ff[0]) | (hist_ff[1] & rx) | (hist_ff[0] & rx);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      presc_ff <= PRESC_RST;
      q_ff <= QPOS_RST;
      ext_ff <= QPOS_RST;
      hist_ff <= {3{RECESSIVE}};
      samp_ff <= 1'b0;
      start_ff <= 1'b0;
      bit_ff <= RECESSIVE;
    end else if (ce) begin
      samp_ff <= 1'b0;
      start_ff <= 1'b0;
      // RQ21 quantum clock divider
      if (run && mod_tick) presc_ff <= tq ? PRESC_RST : presc_ff + 6'h01;
      if (tq) begin
        hist_ff <= {hist_ff[1:0], rx};
        // RQ26 bit length from segments
        if (at_end) begin
          q_ff <= QPOS_RST;
          ext_ff <= QPOS_RST;
          start_ff <= 1'b1;
        // RQ23 jump width bounds correction
        end else if (fall && in_t1) begin
          ext_ff <= (q_ff < sjw_q) ? q_ff : sjw_q;
          q_ff <= q_ff + 6'h01;
        end else if (fall) begin
          q_ff <= jump_q;
        end else begin
          q_ff <= q_ff + 6'h01;
        end
        // RQ24 sample at segment end
        if (q_ff == samp_q) begin
          samp_ff <= 1'b1;
          bit_ff <= cfg.three_samp ? maj : rx;
        end
      end
    end
  end

  assign sample_pt = samp_ff;
  assign bit_start = start_ff;
  assign rx_bit = bit_ff;

endmodule // cpmbt_tq

// *** test/cpmbt_bus_node.sv ***
// Bus node model: wired-AND wire with a commanded dominant pull
`timescale 1ns/1ps
module cpmbt_bus_node (
  input wire logic tx,
  input wire logic pull,
  output logic rx
);
  // Dominant wins; released wire rests recessive through the pull-up
  assign rx = tx & ~pull;
endmodule // cpmbt_bus_node

// *** test/cpmbt_assertions.sv ***
// Port checker for the CAN power-mode and bit-timing block
`timescale 1ns/1ps
module cpmbt_assertions import cpmbt_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sleep_request,
  input wire logic soft_reset_request,
  input wire logic cpu_stop,
  input wire logic timer_link_enable,
  input wire cpmbt_proto_t proto,
  input wire logic can_tx_pin,
  input wire logic sleep_acknowledge,
  input wire logic sleep_request_held,
  input wire logic register_access_enable,
  input wire logic abort_all,
  input wire logic engine_sample,
  input wire logic frame_valid_pulse,
  input wire logic first_timer_module_ch0
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic busy = proto.tx_active | proto.rx_active | proto.tx_pending;
  wire logic calm = !soft_reset_request && !cpu_stop;
  sequence quiet_req;
    sleep_request && !busy && calm;
  endsequence
  sequence held_stop;
    cpu_stop [*4];
  endsequence
  idle_sleep_a: assert property ($rose(sleep_request) ##0 quiet_req |-> ##[1:2] sleep_acknowledge)
    else $error("sleep not entered at once while idle");
  busy_hold_a: assert property (sleep_request && busy && $past(busy) && !sleep_acknowledge |=> !sleep_acknowledge)
    else $error("sleep entered while busy");
  sleep_tx_a: assert property (sleep_acknowledge && $past(sleep_acknowledge) |-> can_tx_pin)
    else $error("transmit not recessive in sleep");
  no_sample_a: assert property (sleep_acknowledge && $past(sleep_acknowledge) |-> !engine_sample)
    else $error("sampling while asleep");
  held_req_a: assert property (sleep_request_held && !sleep_acknowledge && calm && !sleep_request |=> sleep_request_held)
    else $error("sleep request dropped before acknowledge");
  pdown_a: assert property (held_stop |-> !register_access_enable && can_tx_pin)
    else $error("power-down not enforced");
  soft_tx_a: assert property (soft_reset_request [*3] |-> can_tx_pin)
    else $error("transmit not recessive in soft reset");
  stop_abort_a: assert property ($rose(cpu_stop) && !sleep_acknowledge && !soft_reset_request |-> ##[1:2] abort_all)
    else $error("no abort on power-down");
  link_route_a: assert property ($stable(timer_link_enable) |->
    first_timer_module_ch0 == (frame_valid_pulse && timer_link_enable))
    else $error("timer link routing wrong");
endmodule // cpmbt_assertions

// *** test/cpmbt_top_bench.sv ***
// Self-checking bench for the CAN power-mode and bit-timing block
`timescale 1ns/1ps
module cpmbt_top_bench import cpmbt_pkg::*;;
  logic clk = 1'b0, nrst = 1'b0, osc_tick = 1'b1, pll_tick = 1'b0, clock_source_select = 1'b0;
  logic engine_tx_bit = 1'b1, sleep_request = 1'b0, soft_reset_request = 1'b0, wakeup_filter_select = 1'b0;
  logic timer_link_enable = 1'b0, cpu_stop = 1'b0, cpu_wait = 1'b0, pull = 1'b0;
  logic [2:0] irq_pending = 3'h0;
  cpmbt_timing_t timing = 16'h0032;
  cpmbt_proto_t proto = 5'h00;
  cpmbt_timing_t tbl [4] = '{16'h0032, 16'h04FE, 16'h0000, 16'h0045};
  logic can_tx_pin, can_rx_pin, sleep_acknowledge, sleep_request_held, bus_joined, engine_sample;
  logic register_access_enable, abort_all, wakeup_event, busoff_recovered, frame_valid_pulse, wait_wakeup;
  logic engine_rx_bit, deferred_action_enable, first_timer_module_ch0;
  int errors = 0, checked = 0, cycles = 0, n, e;

  cpmbt_bus_node i_cpmbt_bus_node (.tx(can_tx_pin), .pull(pull), .rx(can_rx_pin));
  cpmbt_top i_cpmbt_top (.clk, .nrst, .ce(1'b1), .osc_tick, .pll_tick, .clock_source_select, .timing,
    .can_rx_pin, .engine_tx_bit, .proto, .sleep_request, .soft_reset_request, .wakeup_filter_select,
    .timer_link_enable, .cpu_stop, .cpu_wait, .irq_pending, .can_tx_pin, .sleep_acknowledge,
    .sleep_request_held, .bus_joined, .engine_rx_bit, .engine_sample, .deferred_action_enable,
    .register_access_enable, .abort_all, .wakeup_event, .busoff_recovered, .frame_valid_pulse,
    .first_timer_module_ch0, .wait_wakeup);

  initial forever #20 clk = ~clk;
  // PLL tick at half rate so the source choice shows in the bit length
  always @(negedge clk) pll_tick <= ~pll_tick;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end

  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic join_bus();
    n = 0;
    while (bus_joined !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic period(output int p);
    @(posedge engine_sample);
    @(negedge clk);
    p = 0;
    do begin
      @(negedge clk);
      p++;
    end while (engine_sample !== 1'b1);
  endtask
  task automatic complete_run();
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    cyc(10);
    nrst = 1'b1;
    cyc(60);
    cmp(bus_joined, 1'b0);
    join_bus();
    cmp(bus_joined, 1'b1);
    pull = 1'b1;
    cyc(20);
    cmp(engine_rx_bit, 1'b0);
    pull = 1'b0;
    cyc(20);
    cmp(engine_rx_bit, 1'b1);
    for (int i = 0; i < 4; i++) begin
      timing = tbl[i];
      clock_source_select = (i == 3);
      e = 3 + (timing.first_time_segment_length < 4'h3 ? 3 : timing.first_time_segment_length) + (timing.second_time_segment_length < 3'h1 ? 1 : timing.second_time_segment_length);
      e = e * (timing.presc + 1) * (clock_source_select ? 2 : 1);
      period(n);
      period(n);
      cmp(16'(n), 16'(e));
    end
    timing = 16'h0032;
    clock_source_select = 1'b0;
    period(n);
    for (int i = 0; i < 2; i++) begin
      timer_link_enable = (i == 0);
      cyc(2);
      proto = 5'h01;
      cyc(1);
      proto = 5'h00;
      @(posedge frame_valid_pulse);
      @(negedge clk);
      n = 0;
      while (frame_valid_pulse === 1'b1) begin
        cmp(first_timer_module_ch0, 16'(i == 0));
        n++;
        @(negedge clk);
      end
      cmp(16'(n), 16'h0007);
    end
    timer_link_enable = 1'b0;
    // Busy kinds in turn, each woken by a different cause
    for (int k = 0; k < 3; k++) begin
      proto = 5'h10 >> k;
      sleep_request = 1'b1;
      cyc(20);
      cmp(sleep_acknowledge, 1'b0);
      sleep_request = 1'b0;
      cyc(2);
      cmp(sleep_request_held, 1'b1);
      sleep_request = 1'b1;
      proto = 5'h00;
      cyc(3);
      cmp(sleep_acknowledge, 1'b1);
      engine_tx_bit = 1'b0;
      cyc(20);
      cmp({sleep_acknowledge, can_tx_pin}, 2'h3);
      cmp(deferred_action_enable, 1'b0);
      engine_tx_bit = 1'b1;
      sleep_request = (k != 0);
      soft_reset_request = (k == 1);
      pull = (k == 2);
      cyc(6);
      cmp(sleep_acknowledge, 1'b0);
      cmp({bus_joined, register_access_enable}, 2'h1);
      cmp(deferred_action_enable, 16'(k != 1));
      {sleep_request, soft_reset_request, pull} = 3'h0;
      join_bus();
    end
    wakeup_filter_select = 1'b1;
    sleep_request = 1'b1;
    for (int k = 0; k < 2; k++) begin
      cyc(4);
      pull = 1'b1;
      cyc(k ? 70 : 30);
      pull = 1'b0;
      cyc(6);
      cmp(sleep_acknowledge, 16'(k == 0));
    end
    {sleep_request, wakeup_filter_select} = 2'h0;
    // sleep first, so soft reset cuts nothing off
    cyc(2);
    sleep_request = 1'b1;
    cyc(3);
    cmp(sleep_acknowledge, 1'b1);
    soft_reset_request = 1'b1;
    n = 0;
    repeat (3) begin
      @(negedge clk);
      n |= abort_all;
    end
    cmp(16'(n), 16'h0000);
    {sleep_request, soft_reset_request} = 2'h0;
    // Soft reset, then power-down, both from a running joined state
    for (int k = 0; k < 2; k++) begin
      join_bus();
      n = 0;
      {cpu_stop, soft_reset_request} = k ? 2'h2 : 2'h1;
      repeat (3) begin
        @(negedge clk);
        n |= abort_all;
      end
      cmp(16'(n), 16'h0001);
      cmp(register_access_enable, 16'(k == 0));
      pull = 1'b1;
      cyc(8);
      cmp(wakeup_event, 16'(k));
      pull = 1'b0;
      cyc(4);
      {cpu_stop, soft_reset_request} = 2'h0;
      cyc(3);
      cmp(bus_joined, 1'b0);
    end
    cpu_wait = 1'b1;
    for (int b = 0; b < 3; b++) begin
      irq_pending = 3'h1 << b;
      cyc(3);
      cmp(wait_wakeup, 1'b1);
      irq_pending = 3'h0;
      cyc(3);
      cmp(wait_wakeup, 1'b0);
    end
    cpu_wait = 1'b0;
    join_bus();
    // Bus-off count of 128 x 11 bits at 7 cycles a bit, paused by sleep
    proto = 5'h02;
    cyc(2000);
    sleep_request = 1'b1;
    cyc(3000);
    sleep_request = 1'b0;
    n = 2000;
    while (busoff_recovered !== 1'b1 && n < 12000) begin
      @(negedge clk);
      n++;
    end
    cmp(16'(n > 9800 && n < 10050), 16'h0001);
    proto = 5'h00;
    complete_run();
  end
endmodule // cpmbt_top_bench

bind cpmbt_top cpmbt_assertions i_cpmbt_assertions (.clk, .nrst, .sleep_request, .soft_reset_request,
  .cpu_stop, .timer_link_enable, .proto, .can_tx_pin, .sleep_acknowledge, .sleep_request_held,
  .register_access_enable, .abort_all, .engine_sample, .frame_valid_pulse, .first_timer_module_ch0);
